// ---- hw/ttc_pkg.sv ----
/*
 * Package of the overtemperature timer, tach pulse and config register bank.
 * Assumes a 250 MHz system clock and byte addressing on the register bus.
 */
package ttc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_INT_STATUS_TWO    = 8'h42;
    localparam logic [7:0] IDX_CONFIG_ONE        = 8'h40;
    localparam logic [7:0] IDX_INT_MASK_TWO      = 8'h75;
    localparam logic [7:0] IDX_TIMER_STATUS      = 8'h79;
    localparam logic [7:0] IDX_DURATION_LIMIT    = 8'h7a;
    localparam logic [7:0] IDX_PULSES_PER_REV    = 8'h7b;
    localparam logic [7:0] IDX_CONFIG_FIVE       = 8'h7c;
    localparam logic [7:0] IDX_CONFIG_FOUR       = 8'h7d;
    localparam logic [7:0] IDX_PORT_PIN_CTRL     = 8'h80;

    localparam int unsigned ADDR_W = 10;

    // Reset values
    localparam logic [7:0] RST_DURATION_LIMIT = 8'h00;
    localparam logic [7:0] RST_PULSES_PER_REV = 8'h55;
    localparam logic [7:0] RST_CONFIG_FIVE    = 8'h01;
    localparam logic [7:0] RST_ZERO           = 8'h00;

    // Field positions
    localparam int unsigned BIT_FAULT_FLAG    = 5;
    localparam int unsigned BIT_LOCK          = 1;
    localparam int unsigned BIT_TEMP_FORMAT   = 0;
    localparam int unsigned BIT_OFFSET_RANGE  = 1;
    localparam int unsigned BIT_PIN_DIRECTION = 2;
    localparam int unsigned BIT_PIN_POLARITY  = 3;
    localparam int unsigned BIT_REMOTE_ONE    = 5;
    localparam int unsigned BIT_PIN_ASSERT    = 0;
    localparam int unsigned BIT_PIN_LEVEL     = 1;

    // Writable bits of config five; bit 4 is reserved
    localparam logic [7:0] MASK_CONFIG_FIVE   = 8'h2f;
    localparam logic [7:0] MASK_CONFIG_FOUR   = 8'h03;
    localparam logic [7:0] MASK_FAULT_FLAG    = 8'h20;

    localparam logic [1:0] PIN_FUNC_GPIO      = 2'h3;

    // Overtemperature limits that disable a channel
    localparam logic [7:0] LIMIT_OFF_OFFSET64 = 8'h00;
    localparam logic [7:0] LIMIT_OFF_TWOS     = 8'h80;

    // Timer step of 22.76 ms
    localparam longint unsigned STEP_TIME_NS  = 64'd22760000;
    localparam longint unsigned CLK_PERIOD_NS = 64'd4;
    localparam int unsigned STEP_CYCLES       = int'(STEP_TIME_NS / CLK_PERIOD_NS);
    localparam logic [7:0] REPORT_MIN_STEPS   = 8'h02;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } ttc_bus_state_type;

endpackage : ttc_pkg

// ---- hw/ttc_regs.sv ----
/*
 * Overtemperature duration timer, tach pulse selection and config five bank.
 * Assumes an Avalon-MM master and inputs synchronous to SYS_CLK_I.
 */
// The Avalon-MM interface to the registers was left to the implementer.
// Notes on behaviour
// - Eight-bit duration limit, 22.76 ms per step
// - Exceeding limit sets fault flag bit five
// - Zero limit flags on assertion immediately
// - Two-bit fields pick one to four pulses
// - Pulses register resets to 0x55
// - Format bit selects twos complement or offset
// - Config five resets to 0x01
// - Range bit picks offset step and span
// - Direction bit makes pin input or output
// - Polarity bit sets output active level
// - Remote one overtemperature disable bit
// - Minimum-value limit disables channel overtemperature
// - Lock bit makes config registers read-only
// - Time assertion, report steps past 45.52 ms
// - Pin function active only when select is 11
`timescale 1ns/1ps
`default_nettype none

module ttc_regs #(
    parameter int unsigned STEP_CYCLES = ttc_pkg::STEP_CYCLES
) (
    input  wire logic                        SYS_CLK_I,
    input  wire logic                        RST_I,
    input  wire logic [ttc_pkg::ADDR_W-1:0]  AVS_ADDRESS_I,
    input  wire logic                        AVS_READ_I,
    input  wire logic                        AVS_WRITE_I,
    input  wire logic [31:0]                 AVS_WRITEDATA_I,
    input  wire logic [3:0]                  AVS_BYTEENABLE_I,
    output logic [31:0]                      AVS_READDATA_O,
    output logic                             AVS_WAITREQUEST_O,
    output logic                             IRQ_O,
    input  wire logic                        OVERTEMP_SIGNAL_I,
    input  wire logic                        REMOTE_ONE_OVER_LIMIT_I,
    input  wire logic [7:0]                  REMOTE_ONE_LIMIT_I,
    output logic                             REMOTE_ONE_OVERTEMP_O,
    output logic                             TEMP_FORMAT_SELECT_O,
    output logic                             OFFSET_RANGE_SELECT_O,
    output logic [2:0]                       FIRST_FAN_PULSE_COUNT_O,
    output logic [2:0]                       SECOND_FAN_PULSE_COUNT_O,
    output logic [2:0]                       THIRD_FAN_PULSE_COUNT_O,
    output logic [2:0]                       FOURTH_FAN_PULSE_COUNT_O,
    input  wire logic                        GPIO_I,
    output logic                             GPIO_O,
    output logic                             GPIO_OE_O
);

    ttc_pkg::ttc_bus_state_type bus_state_reg;
    ttc_pkg::ttc_bus_state_type bus_state_next;

    logic [7:0]  limit_reg;
    logic [7:0]  ppr_reg;
    logic [7:0]  cfg5_reg;
    logic [7:0]  cfg4_reg;
    logic [7:0]  status_reg;
    logic [7:0]  mask_reg;
    logic        lock_reg;
    logic        pin_assert_reg;
    logic        asrt_reg;
    logic [7:0]  cnt_reg;
    logic [22:0] presc_reg;
    logic        overtemp_prev_reg;
    logic [31:0] rdata_reg;

    wire logic       req;
    wire logic       ack;
    wire logic       wr_ack;
    wire logic       rd_ack;
    wire logic [7:0] idx;
    wire logic [7:0] wdata;
    wire logic       wr_lane;
    wire logic       cfg_wr_ok;
    wire logic       wr_limit;
    wire logic       wr_ppr;
    wire logic       wr_cfg5;
    wire logic       wr_cfg4;
    wire logic       wr_cfg1;
    wire logic       wr_mask;
    wire logic       wr_pin;
    wire logic       rd_status;
    wire logic       rd_timer;
    wire logic       step_end;
    wire logic       assert_rise;
    wire logic       fault_set;
    wire logic       pin_enabled;
    wire logic       limit_off;
    wire logic [7:0] timer_view;
    wire logic [7:0] rd_mux;

    assign req    = AVS_READ_I | AVS_WRITE_I;
    assign ack    = bus_state_reg == ttc_pkg::BUS_ACK;
    assign wr_ack = ack & AVS_WRITE_I;
    assign rd_ack = ack & AVS_READ_I;
    assign idx    = AVS_ADDRESS_I[ttc_pkg::ADDR_W-1:2];
    assign wdata  = AVS_WRITEDATA_I[7:0];
    // Only the low lane carries data; other lanes are ignored
    assign wr_lane = wr_ack & AVS_BYTEENABLE_I[0];
    assign cfg_wr_ok = wr_lane & ~lock_reg;

    assign wr_limit = cfg_wr_ok & (idx == ttc_pkg::IDX_DURATION_LIMIT);
    assign wr_ppr   = cfg_wr_ok & (idx == ttc_pkg::IDX_PULSES_PER_REV);
    assign wr_cfg5  = cfg_wr_ok & (idx == ttc_pkg::IDX_CONFIG_FIVE);
    assign wr_cfg4  = cfg_wr_ok & (idx == ttc_pkg::IDX_CONFIG_FOUR);
    assign wr_cfg1  = wr_lane & (idx == ttc_pkg::IDX_CONFIG_ONE);
    assign wr_mask  = wr_lane & (idx == ttc_pkg::IDX_INT_MASK_TWO);
    assign wr_pin   = wr_lane & (idx == ttc_pkg::IDX_PORT_PIN_CTRL);
    assign rd_status = rd_ack & (idx == ttc_pkg::IDX_INT_STATUS_TWO);
    assign rd_timer  = rd_ack & (idx == ttc_pkg::IDX_TIMER_STATUS);

    // Bus handshake: one wait cycle, then the answer
    assign AVS_WAITREQUEST_O = req & ~ack;
    assign AVS_READDATA_O    = rdata_reg;

    always_comb
    begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            ttc_pkg::BUS_IDLE:
            begin
                if (req)
                begin
                    bus_state_next = ttc_pkg::BUS_ACK;
                end
            end
            ttc_pkg::BUS_ACK:
            begin
                bus_state_next = ttc_pkg::BUS_IDLE;
            end
            default:
            begin
                bus_state_next = ttc_pkg::BUS_IDLE;
            end
        endcase
    end

    // Timer reads zero above bit 0 until two steps have passed
    assign timer_view = (cnt_reg >= ttc_pkg::REPORT_MIN_STEPS) ? cnt_reg
                        : {7'h00, asrt_reg};

    assign rd_mux =
        (idx == ttc_pkg::IDX_DURATION_LIMIT) ? limit_reg :
        (idx == ttc_pkg::IDX_PULSES_PER_REV) ? ppr_reg :
        (idx == ttc_pkg::IDX_CONFIG_FIVE)    ? (cfg5_reg & ttc_pkg::MASK_CONFIG_FIVE) :
        (idx == ttc_pkg::IDX_CONFIG_FOUR)    ? cfg4_reg :
        (idx == ttc_pkg::IDX_CONFIG_ONE)     ? {6'h00, lock_reg, 1'b0} :
        (idx == ttc_pkg::IDX_INT_STATUS_TWO) ? status_reg :
        (idx == ttc_pkg::IDX_INT_MASK_TWO)   ? mask_reg :
        (idx == ttc_pkg::IDX_TIMER_STATUS)   ? timer_view :
        (idx == ttc_pkg::IDX_PORT_PIN_CTRL)  ? {6'h00, GPIO_I, pin_assert_reg} :
        ttc_pkg::RST_ZERO;

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            bus_state_reg <= ttc_pkg::BUS_IDLE;
            rdata_reg     <= 32'h0000_0000;
        end
        else
        begin
            bus_state_reg <= bus_state_next;
            if (req & ~ack)
            begin
                rdata_reg <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Configuration registers
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            limit_reg      <= ttc_pkg::RST_DURATION_LIMIT;
            ppr_reg        <= ttc_pkg::RST_PULSES_PER_REV;
            cfg5_reg       <= ttc_pkg::RST_CONFIG_FIVE;
            cfg4_reg       <= ttc_pkg::RST_ZERO;
            mask_reg       <= ttc_pkg::RST_ZERO;
            lock_reg       <= 1'b0;
            pin_assert_reg <= 1'b0;
        end
        else
        begin
            if (wr_limit)
                limit_reg <= wdata;
            if (wr_ppr)
                ppr_reg <= wdata;
            if (wr_cfg5)
                cfg5_reg <= wdata & ttc_pkg::MASK_CONFIG_FIVE;
            if (wr_cfg4)
                cfg4_reg <= wdata & ttc_pkg::MASK_CONFIG_FOUR;
            if (wr_mask)
                mask_reg <= wdata & ttc_pkg::MASK_FAULT_FLAG;
            // Lock stays set until reset
            if (wr_cfg1 & wdata[ttc_pkg::BIT_LOCK])
                lock_reg <= 1'b1;
            if (wr_pin)
                pin_assert_reg <= wdata[ttc_pkg::BIT_PIN_ASSERT];
        end
    end

    // Assertion timer; counts accumulate until read, saturating at full scale
    assign step_end    = presc_reg == 23'(STEP_CYCLES - 1);
    assign assert_rise = OVERTEMP_SIGNAL_I & ~overtemp_prev_reg;
    assign fault_set   = (limit_reg == 8'h00) ? assert_rise
                         : (cnt_reg > limit_reg);

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            presc_reg         <= 23'h00_0000;
            cnt_reg           <= 8'h00;
            asrt_reg          <= 1'b0;
            overtemp_prev_reg <= 1'b0;
        end
        else
        begin
            overtemp_prev_reg <= OVERTEMP_SIGNAL_I;
            if (!OVERTEMP_SIGNAL_I || step_end)
                presc_reg <= 23'h00_0000;
            else
                presc_reg <= presc_reg + 23'h00_0001;
            // New assertion wins over a clearing read
            if (assert_rise)
                asrt_reg <= 1'b1;
            else if (rd_timer)
                asrt_reg <= 1'b0;
            if (OVERTEMP_SIGNAL_I && step_end && cnt_reg != 8'hff)
                cnt_reg <= cnt_reg + 8'h01;
            else if (rd_timer)
                cnt_reg <= 8'h00;
        end
    end

    // Sticky status; set wins over clear on read
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
            status_reg <= ttc_pkg::RST_ZERO;
        else if (fault_set)
            status_reg <= status_reg | ttc_pkg::MASK_FAULT_FLAG;
        else if (rd_status)
            status_reg <= ttc_pkg::RST_ZERO;
    end

    // Mask bit set hides the fault
    assign IRQ_O = |(status_reg & ~mask_reg);

    assign TEMP_FORMAT_SELECT_O  = cfg5_reg[ttc_pkg::BIT_TEMP_FORMAT];
    assign OFFSET_RANGE_SELECT_O = cfg5_reg[ttc_pkg::BIT_OFFSET_RANGE];

    assign FIRST_FAN_PULSE_COUNT_O  = {1'b0, ppr_reg[1:0]} + 3'h1;
    assign SECOND_FAN_PULSE_COUNT_O = {1'b0, ppr_reg[3:2]} + 3'h1;
    assign THIRD_FAN_PULSE_COUNT_O  = {1'b0, ppr_reg[5:4]} + 3'h1;
    assign FOURTH_FAN_PULSE_COUNT_O = {1'b0, ppr_reg[7:6]} + 3'h1;

    assign pin_enabled = cfg4_reg[1:0] == ttc_pkg::PIN_FUNC_GPIO;
    assign GPIO_OE_O = pin_enabled & cfg5_reg[ttc_pkg::BIT_PIN_DIRECTION];
    // While the output is disabled, GPIO_O carries the inverted assert bit, the same level that polarity zero drives
    assign GPIO_O = GPIO_OE_O & cfg5_reg[ttc_pkg::BIT_PIN_POLARITY] ? pin_assert_reg
                    : ~pin_assert_reg;

    // Minimum limit value depends on the current format
    assign limit_off = TEMP_FORMAT_SELECT_O
                       ? (REMOTE_ONE_LIMIT_I == ttc_pkg::LIMIT_OFF_TWOS)
                       : (REMOTE_ONE_LIMIT_I == ttc_pkg::LIMIT_OFF_OFFSET64);
    assign REMOTE_ONE_OVERTEMP_O = REMOTE_ONE_OVER_LIMIT_I & ~limit_off
                                   & ~cfg5_reg[ttc_pkg::BIT_REMOTE_ONE];

    sequence s_cfg_write(logic [7:0] which);
        wr_ack && AVS_BYTEENABLE_I[0] && !lock_reg && idx == which;
    endsequence

    sequence s_status_clear;
        rd_status && !fault_set;
    endsequence

    property p_fault_on_exceed;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (limit_reg != 8'h00 && cnt_reg > limit_reg) |=> status_reg[ttc_pkg::BIT_FAULT_FLAG];
    endproperty
    a_fault_on_exceed: assert property (p_fault_on_exceed)
        else $error("fault flag not set after limit exceeded");

    property p_zero_limit;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (limit_reg == 8'h00 && OVERTEMP_SIGNAL_I && !overtemp_prev_reg) |=> IRQ_O || mask_reg[5];
    endproperty
    a_zero_limit: assert property (p_zero_limit)
        else $error("zero limit did not flag on assertion");

    property p_pulse_write;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        s_cfg_write(ttc_pkg::IDX_PULSES_PER_REV) |=>
            FOURTH_FAN_PULSE_COUNT_O == {1'b0, $past(wdata[7:6])} + 3'h1;
    endproperty
    a_pulse_write: assert property (p_pulse_write)
        else $error("fourth fan pulse count wrong after write");

    property p_defaults;
        @(posedge SYS_CLK_I) $fell(RST_I) |-> ppr_reg == ttc_pkg::RST_PULSES_PER_REV
            && cfg5_reg == ttc_pkg::RST_CONFIG_FIVE && TEMP_FORMAT_SELECT_O;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("reset values wrong");

    property p_locked;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        lock_reg |=> $stable(limit_reg) && $stable(ppr_reg) && $stable(cfg5_reg)
            && $stable(cfg4_reg) && lock_reg;
    endproperty
    a_locked: assert property (p_locked)
        else $error("config changed while locked");

    property p_reserved;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        s_cfg_write(ttc_pkg::IDX_CONFIG_FIVE) |=> !cfg5_reg[4]
            && cfg5_reg[5] == $past(wdata[5]);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit stored or bit five lost");

    property p_pin_drive;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        GPIO_OE_O |-> cfg4_reg[1:0] == 2'h3 && (GPIO_O == (cfg5_reg[3] ? pin_assert_reg
            : !pin_assert_reg));
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("pin driven with wrong level or function");

    property p_remote_off;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (cfg5_reg[5] || (cfg5_reg[0] && REMOTE_ONE_LIMIT_I == 8'h80)
            || (!cfg5_reg[0] && REMOTE_ONE_LIMIT_I == 8'h00)) |-> !REMOTE_ONE_OVERTEMP_O;
    endproperty
    a_remote_off: assert property (p_remote_off)
        else $error("remote one overtemperature not suppressed");

    property p_step_count;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (OVERTEMP_SIGNAL_I && step_end && cnt_reg < 8'hff) |=> cnt_reg == $past(cnt_reg) + 8'h01;
    endproperty
    a_step_count: assert property (p_step_count)
        else $error("timer step not counted");

    property p_status_clear;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        s_status_clear |=> status_reg == 8'h00 ##1 !IRQ_O || fault_set || $past(fault_set);
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status not cleared by read");

endmodule : ttc_regs

`default_nettype wire

// ---- test/ttc_far_side.sv ----
/*
 * Far-side model: overtemperature source and the shared pin's wire.
 * Assumes the bench starts a pulse with a one-cycle go strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module ttc_far_side (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [31:0] len_i,
    input  wire logic       pin_out_i,
    input  wire logic       pin_oe_i,
    output logic            overtemp_o,
    output logic            pin_in_o
);
    int left_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            left_reg <= 0;
        else if (go_i)
            left_reg <= len_i;
        else if (left_reg != 0)
            left_reg <= left_reg - 1;
    end

    assign overtemp_o = (left_reg != 0);
    // Pull-up on the pin: released wire reads high
    assign pin_in_o   = pin_oe_i ? pin_out_i : 1'b1;
endmodule : ttc_far_side

`default_nettype wire

// ---- test/ttc_regs_bench.sv ----
/*
 * Self-checking bench of the timer, tach pulse and config register bank.
 * Assumes the far-side model and a four-cycle timer step.
 */
`timescale 1ns/1ps
`default_nettype none

module ttc_regs_bench;
    localparam int unsigned STEP = 4;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  addr = '0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0]  be = 4'h1;
    logic [31:0] rdata;
    logic        waitreq, irq, ot, r1_out, fmt, rng, pin_i, pin_o, pin_oe;
    logic        r1_over = 1'b0;
    logic [7:0]  r1_limit = 8'h40;
    logic [2:0]  c1, c2, c3, c4;
    logic [11:0] counts;
    assign counts = {c4, c3, c2, c1};
    logic        ot_go = 1'b0;
    int          ot_len = 0;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    ttc_regs #(.STEP_CYCLES(STEP)) dut_u (
        .SYS_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .IRQ_O(irq),
        .OVERTEMP_SIGNAL_I(ot), .REMOTE_ONE_OVER_LIMIT_I(r1_over),
        .REMOTE_ONE_LIMIT_I(r1_limit), .REMOTE_ONE_OVERTEMP_O(r1_out),
        .TEMP_FORMAT_SELECT_O(fmt), .OFFSET_RANGE_SELECT_O(rng),
        .FIRST_FAN_PULSE_COUNT_O(c1), .SECOND_FAN_PULSE_COUNT_O(c2),
        .THIRD_FAN_PULSE_COUNT_O(c3), .FOURTH_FAN_PULSE_COUNT_O(c4),
        .GPIO_I(pin_i), .GPIO_O(pin_o), .GPIO_OE_O(pin_oe));

    ttc_far_side far_u (
        .clk_i(clk), .rst_i(rst), .go_i(ot_go), .len_i(ot_len), .pin_out_i(pin_o),
        .pin_oe_i(pin_oe), .overtemp_o(ot), .pin_in_o(pin_i));

    always #2 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // Ceiling well above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            failures++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        @(posedge clk);
        // Only the edge with waitrequest low completes the transfer
        while (waitreq !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 100)
            chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
        @(posedge clk);
    endtask : wreg

    task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(what, {24'h00_0000, exp}, q);
    endtask : rchk

    task automatic heat(input int n);
        @(posedge clk);
        ot_len <= n;
        ot_go <= 1'b1;
        @(posedge clk);
        ot_go <= 1'b0;
        repeat (n + 3) @(posedge clk);
    endtask : heat

    task automatic t_reset();
        rchk("limit rst", 8'h7a, 8'h00);
        rchk("ppr rst", 8'h7b, 8'h55);
        rchk("cfg5 rst", 8'h7c, 8'h01);
        chk("counts rst", {4{3'h2}}, {c4, c3, c2, c1});
        chk("fmt rst", 1, fmt);
        wreg(8'h7e, 8'haa);
        rchk("unmapped", 8'h7e, 8'h00);
    endtask : t_reset

    task automatic t_pulses();
        logic [7:0] v [3] = '{8'he4, 8'h1b, 8'h55};
        for (int k = 0; k < 3; k++)
        begin
            wreg(8'h7b, v[k]);
            rchk("ppr", 8'h7b, v[k]);
            for (int i = 0; i < 4; i++)
                chk("count", 3'(v[k][2*i +: 2]) + 3'h1, counts[3*i +: 3]);
        end
    endtask : t_pulses

    task automatic t_cfg5();
        wreg(8'h7c, 8'hff);
        rchk("cfg5 res", 8'h7c, 8'h2f);
        chk("range 1", 1, rng);
        wreg(8'h7c, 8'h00);
        chk("fmt 0", 0, fmt);
        chk("range 0", 0, rng);
        wreg(8'h7c, 8'h01);
        chk("fmt 1", 1, fmt);
    endtask : t_cfg5

    task automatic t_pin();
        wreg(8'h7d, 8'h03);
        wreg(8'h80, 8'h01);
        wreg(8'h7c, 8'h0d);
        chk("oe out", 1, pin_oe);
        chk("pin high", 1, pin_o);
        rchk("pin rd", 8'h80, 8'h03);
        wreg(8'h7c, 8'h05);
        chk("pin low", 0, pin_o);
        rchk("pin rd low", 8'h80, 8'h01);
        wreg(8'h7d, 8'h02);
        chk("oe func", 0, pin_oe);
        wreg(8'h7d, 8'h03);
        wreg(8'h7c, 8'h01);
        chk("oe in", 0, pin_oe);
        rchk("pin pullup", 8'h80, 8'h03);
    endtask : t_pin

    task automatic t_remote();
        logic [7:0] cfg [6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h21};
        logic [7:0] lim [6] = '{8'h40, 8'h80, 8'h00, 8'h00, 8'h80, 8'h40};
        logic       exp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        r1_over <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            wreg(8'h7c, cfg[k]);
            r1_limit <= lim[k];
            @(posedge clk);
            chk("remote one", exp[k], r1_out);
        end
        wreg(8'h7c, 8'h01);
    endtask : t_remote

    task automatic t_timer();
        heat(2);
        chk("irq zero lim", 1, irq);
        rchk("flag zero lim", 8'h42, 8'h20);
        // Clear lands at the answer edge; look one edge later
        @(posedge clk);
        chk("irq clr", 0, irq);
        rchk("assert bit", 8'h79, 8'h01);
        wreg(8'h7a, 8'h03);
        heat(1);
        rchk("no flag short", 8'h42, 8'h00);
        rchk("clear bit", 8'h79, 8'h01);
        heat(10);
        rchk("no flag two", 8'h42, 8'h00);
        rchk("count two", 8'h79, 8'h02);
        heat(22);
        chk("irq over", 1, irq);
        rchk("flag over", 8'h42, 8'h20);
        rchk("count five", 8'h79, 8'h05);
        wreg(8'h7a, 8'h00);
        wreg(8'h75, 8'h20);
        heat(2);
        chk("irq masked", 0, irq);
        rchk("flag masked", 8'h42, 8'h20);
        wreg(8'h75, 8'h00);
        rchk("timer drained", 8'h79, 8'h01);
    endtask : t_timer

    task automatic t_lock();
        be <= 4'h0;
        wreg(8'h7b, 8'h00);
        be <= 4'h1;
        rchk("be ignored", 8'h7b, 8'h55);
        wreg(8'h40, 8'h02);
        wreg(8'h7a, 8'h11);
        wreg(8'h7b, 8'h00);
        wreg(8'h7c, 8'h00);
        rchk("lock lim", 8'h7a, 8'h00);
        rchk("lock ppr", 8'h7b, 8'h55);
        rchk("lock cfg5", 8'h7c, 8'h01);
        chk("lock fmt", 1, fmt);
    endtask : t_lock

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pulses();
        t_cfg5();
        t_pin();
        t_remote();
        t_timer();
        t_lock();
        report_and_stop();
    end
endmodule : ttc_regs_bench

`default_nettype wire
